/* File: core/pcs_consts.svh */
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// Register byte offsets on the APB slave
`define PCS_OFF_LOW 12'h000
`define PCS_OFF_LATCH 12'h004
`define PCS_OFF_WINDOW 12'h008
`define PCS_OFF_POINTER 12'h00C
`define PCS_OFF_STATUS 12'h010
`define PCS_OFF_COUNTER 12'h014

// Field positions
`define PCS_BANK_BIT 7
`define PCS_LATCH_JUMP_HI 4
`define PCS_LATCH_JUMP_LO 3

// Reset values
`define PCS_RST_PC 13'h0000
`define PCS_RST_LATCH 5'h00
`define PCS_RST_POINTER 8'h00
`define PCS_RST_BANK 1'b0

// Interrupt vector and the file address of the window in every bank
`define PCS_VECTOR 13'h0004
`define PCS_WINDOW_FILE 7'h00

`endif

/* File: core/pcs_pkg.sv */
package pcs_pkg;

    typedef logic [12:0] pcs_addr_t;
    typedef logic [10:0] pcs_target_t;

    // Operation presented by the instruction decoder
    typedef enum logic [2:0] {
        PCS_OP_STEP = 3'h0,
        PCS_OP_JUMP = 3'h1,
        PCS_OP_CALL = 3'h2,
        PCS_OP_VECTOR = 3'h3,
        PCS_OP_RETURN = 3'h4,
        PCS_OP_RET_LIT = 3'h5,
        PCS_OP_INT_EXIT = 3'h6,
        PCS_OP_LOW_WRITE = 3'h7
    } pcs_op_t;

    // Separate from the op code: adding to the low byte is a flag on the write
    typedef enum logic [1:0] {
        PCS_ST_IDLE = 2'b00,
        PCS_ST_WAIT = 2'b01,
        PCS_ST_DONE = 2'b11
    } pcs_state_t;

endpackage

/* File: core/pcs_core.sv */
// Behaviour
// - Program counter is a 13-bit register.
// - Low eight counter bits live in a readable, writable low-byte register.
// - Upper five counter bits are readable only through the counter register; writes load them only from the latch.
// - Any reset clears the whole program counter to zero.
// - Writing the low byte loads upper counter bits from latch bits 4..0.
// - Jump or call takes the two top counter bits from latch bits 4 and 3.
// - Return stack is eight entries of 13 bits; its pointer is hidden.
// - Call pushes the program counter plus one onto the stack; interrupt vectoring pushes the program counter itself.
// - Return, return-with-literal and interrupt exit pop the top entry into the counter.
// - Push and pop leave the upper latch unchanged.
// - Stack is circular: the ninth push overwrites the first entry.
// - No overflow or underflow flag exists.
// - Window has no storage; accesses go to the location the pointer selects.
// - Reading through the window when the pointer selects the window gives zero.
// - Writing through the window when it selects itself changes no data.
// - Indirect address is the bank bit on top of the 8-bit pointer.
`include "pcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pcs_core
    import pcs_pkg::*;
#(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder operations on the counter
    input wire logic op_valid,
    input wire pcs_op_t op_code,
    input wire logic op_add,
    input wire logic [10:0] op_target,
    input wire logic [7:0] op_data,
    output logic [12:0] program_counter,
    // Decoder access through the indirect window
    input wire logic win_req,
    input wire logic win_we,
    input wire logic [7:0] win_wdata,
    output logic win_rvalid,
    output logic [7:0] win_rdata,
    // Data memory port
    output logic mem_req,
    output logic mem_we,
    output logic [8:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);

    localparam int PTRW = $clog2(DEPTH);

    pcs_state_t state;
    logic [4:0] counter_upper_latch;
    logic [7:0] indirect_pointer;
    logic indirect_bank_bit;
    logic [PTRW-1:0] stack_ptr;
    pcs_addr_t stack_mem [DEPTH];
    logic s1_valid, s1_self, s1_we, s1_apb;
    logic s2_valid, s2_self, s2_we, s2_apb;

    // APB decode
    logic apb_hit, sel_low, sel_latch, sel_win, sel_ptr, sel_stat, sel_cnt, sel_any;
    assign apb_hit = psel & penable & ~pready & (state == PCS_ST_IDLE);
    assign sel_low = (paddr == `PCS_OFF_LOW);
    assign sel_latch = (paddr == `PCS_OFF_LATCH);
    assign sel_win = (paddr == `PCS_OFF_WINDOW);
    assign sel_ptr = (paddr == `PCS_OFF_POINTER);
    assign sel_stat = (paddr == `PCS_OFF_STATUS);
    assign sel_cnt = (paddr == `PCS_OFF_COUNTER);
    assign sel_any = sel_low | sel_latch | sel_win | sel_ptr | sel_stat | sel_cnt;

    // The decoder owns the counter and memory port; software waits for as long as a clash lasts
    logic apb_stall, apb_pcl_wr, apb_win_go, apb_fin;
    assign apb_stall = apb_hit & ((sel_low & pwrite & op_valid) | (sel_win & win_req));
    assign apb_pcl_wr = apb_hit & pwrite & sel_low & ~op_valid;
    assign apb_win_go = apb_hit & sel_win & ~win_req;
    assign apb_fin = apb_hit & ~sel_win & ~apb_stall;

    logic apb_wr;
    assign apb_wr = apb_fin & pwrite;

    logic [31:0] rd_word;
    assign rd_word = sel_low ? {24'h000000, program_counter[7:0]} :
                     sel_latch ? {27'h0000000, counter_upper_latch} :
                     sel_ptr ? {24'h000000, indirect_pointer} :
                     sel_stat ? {24'h000000, indirect_bank_bit, 7'h00} :
                     sel_cnt ? {19'h00000, program_counter} : 32'h00000000;

    // Counter operations
    logic do_step, do_jump, do_call, do_vec, do_pop, do_wr, do_add, do_push;
    assign do_step = op_valid & (op_code == PCS_OP_STEP);
    assign do_jump = op_valid & (op_code == PCS_OP_JUMP);
    assign do_call = op_valid & (op_code == PCS_OP_CALL);
    assign do_vec = op_valid & (op_code == PCS_OP_VECTOR);
    assign do_pop = op_valid & ((op_code == PCS_OP_RETURN) | (op_code == PCS_OP_RET_LIT)
                    | (op_code == PCS_OP_INT_EXIT));
    assign do_wr = (op_valid & (op_code == PCS_OP_LOW_WRITE) & ~op_add) | apb_pcl_wr;
    assign do_add = op_valid & (op_code == PCS_OP_LOW_WRITE) & op_add;
    assign do_push = do_call | do_vec;

    logic [12:0] pc_inc, push_val, jump_val, wr_val, add_val, next_pc;
    logic [7:0] wr_byte, add_byte;
    logic [PTRW-1:0] ptr_dec;
    assign pc_inc = program_counter + 13'h0001;
    // Call returns past itself; an interrupt returns to the instruction it displaced
    assign push_val = do_call ? pc_inc : program_counter;
    assign ptr_dec = stack_ptr - {{(PTRW-1){1'b0}}, 1'b1};
    assign jump_val = {counter_upper_latch[`PCS_LATCH_JUMP_HI:`PCS_LATCH_JUMP_LO],
                       op_target};
    assign wr_byte = op_valid ? op_data : pwdata[7:0];
    assign wr_val = {counter_upper_latch, wr_byte};
    // Eight-bit sum: a table that crosses a 256-word block wraps inside it
    assign add_byte = program_counter[7:0] + op_data;
    assign add_val = {counter_upper_latch, add_byte};
    assign next_pc = do_pop ? stack_mem[ptr_dec] :
                     (do_jump | do_call) ? jump_val :
                     do_vec ? `PCS_VECTOR :
                     do_wr ? wr_val :
                     do_add ? add_val :
                     do_step ? pc_inc : program_counter;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            program_counter <= `PCS_RST_PC;
        end else begin
            program_counter <= next_pc;
        end
    end

    // Pointer wraps freely; nothing watches it, so no overflow flag exists
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stack_ptr <= '0;
        end else if (do_push) begin
            stack_ptr <= stack_ptr + {{(PTRW-1){1'b0}}, 1'b1};
        end else if (do_pop) begin
            stack_ptr <= ptr_dec;
        end
    end

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_stack
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    stack_mem[i] <= 13'h0000;
                end else if (do_push && stack_ptr == PTRW'(i)) begin
                    stack_mem[i] <= push_val;
                end
            end
        end
    endgenerate

    // Software-visible state; the stack never touches the latch
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            counter_upper_latch <= `PCS_RST_LATCH;
            indirect_pointer <= `PCS_RST_POINTER;
            indirect_bank_bit <= `PCS_RST_BANK;
        end else if (apb_wr) begin
            if (sel_latch) begin
                counter_upper_latch <= pwdata[4:0];
            end
            if (sel_ptr) begin
                indirect_pointer <= pwdata[7:0];
            end
            if (sel_stat) begin
                indirect_bank_bit <= pwdata[`PCS_BANK_BIT];
            end
        end
    end

    // Indirect window: no storage, only a forwarded access
    logic issue, issue_we, win_self;
    logic [7:0] issue_wdata;
    logic [8:0] ind_addr;
    assign issue = win_req | apb_win_go;
    assign issue_we = win_req ? win_we : pwrite;
    assign issue_wdata = win_req ? win_wdata : pwdata[7:0];
    assign ind_addr = {indirect_bank_bit, indirect_pointer};
    assign win_self = (indirect_pointer[6:0] == `PCS_WINDOW_FILE);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 9'h000;
            mem_wdata <= 8'h00;
        end else begin
            mem_req <= issue & ~win_self;
            mem_we <= issue & issue_we & ~win_self;
            mem_addr <= ind_addr;
            mem_wdata <= issue_wdata;
        end
    end

    // Memory answers in the cycle after mem_req; two stages track each access
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_valid <= 1'b0;
            s1_self <= 1'b0;
            s1_we <= 1'b0;
            s1_apb <= 1'b0;
            s2_valid <= 1'b0;
            s2_self <= 1'b0;
            s2_we <= 1'b0;
            s2_apb <= 1'b0;
        end else begin
            s1_valid <= issue;
            s1_self <= win_self;
            s1_we <= issue_we;
            s1_apb <= ~win_req;
            s2_valid <= s1_valid;
            s2_self <= s1_self;
            s2_we <= s1_we;
            s2_apb <= s1_apb;
        end
    end

    logic [7:0] win_byte;
    assign win_byte = s2_self ? 8'h00 : mem_rdata;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            win_rvalid <= 1'b0;
            win_rdata <= 8'h00;
        end else begin
            win_rvalid <= s2_valid & ~s2_apb & ~s2_we;
            win_rdata <= win_byte;
        end
    end

    // APB handshake
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= PCS_ST_IDLE;
        end else begin
            case (state)
                PCS_ST_IDLE: begin
                    if (apb_win_go) begin
                        state <= PCS_ST_WAIT;
                    end
                end
                PCS_ST_WAIT: begin
                    if (s2_valid && s2_apb) begin
                        state <= PCS_ST_DONE;
                    end
                end
                PCS_ST_DONE: begin
                    state <= PCS_ST_IDLE;
                end
                default: begin
                    state <= PCS_ST_IDLE;
                end
            endcase
        end
    end

    logic win_fin;
    assign win_fin = (state == PCS_ST_WAIT) & s2_valid & s2_apb;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_fin | win_fin;
            pslverr <= apb_fin & ~sel_any;
            if (apb_fin) begin
                prdata <= pwrite ? 32'h00000000 : rd_word;
            end else if (win_fin) begin
                prdata <= s2_we ? 32'h00000000 : {24'h000000, win_byte};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Checks
    sequence s_call;
        op_valid && op_code == PCS_OP_CALL;
    endsequence

    sequence s_ret;
        op_valid && op_code == PCS_OP_RETURN;
    endsequence

    a_reset_clear: assert property (@(posedge mclk) !rstn |=> program_counter == 13'h0000)
        else $error("counter not cleared by reset");

    a_jump_load: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_JUMP) |=> program_counter ==
        {$past(counter_upper_latch[4:3]), $past(op_target)})
        else $error("jump target wrong");

    a_low_write: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_LOW_WRITE && !op_add) |=>
        program_counter == {$past(counter_upper_latch), $past(op_data)})
        else $error("low byte write did not load upper bits");

    a_add_nocarry: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_LOW_WRITE && op_add) |=>
        program_counter[12:8] == $past(counter_upper_latch))
        else $error("offset carried into upper bits");

    a_call_return: assert property (@(posedge mclk) disable iff (!rstn)
        s_call ##1 s_ret |=> program_counter == $past(program_counter, 2) + 13'h0001)
        else $error("return did not restore pushed address");

    a_ring_wrap: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_VECTOR) |=> stack_mem[$past(stack_ptr)] ==
        $past(program_counter) && stack_ptr == $past(stack_ptr) + 1'b1)
        else $error("push slot or wrap wrong");

    a_latch_kept: assert property (@(posedge mclk) disable iff (!rstn)
        (do_push || do_pop) && !apb_wr |=> $stable(counter_upper_latch))
        else $error("stack touched the latch");

    a_self_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        (issue && win_self) |=> !mem_req && !mem_we)
        else $error("self-selected window reached memory");

    a_self_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (win_req && !win_we && win_self) |-> ##3 (win_rvalid && win_rdata == 8'h00))
        else $error("self-selected window read not zero");

    a_ind_address: assert property (@(posedge mclk) disable iff (!rstn)
        issue |=> mem_addr == {$past(indirect_bank_bit), $past(indirect_pointer)})
        else $error("indirect address wrong");

    a_call_load: assert property (@(posedge mclk) disable iff (!rstn)
        s_call |=> program_counter ==
        {$past(counter_upper_latch[4:3]), $past(op_target)})
        else $error("call target wrong");

    a_call_push: assert property (@(posedge mclk) disable iff (!rstn)
        s_call |=> stack_mem[$past(stack_ptr)] ==
        $past(program_counter) + 13'h0001)
        else $error("call pushed wrong address");

    a_pop_load: assert property (@(posedge mclk) disable iff (!rstn)
        do_pop |=> program_counter ==
        $past(stack_mem[ptr_dec]))
        else $error("pop did not load top entry");

    a_vector_load: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_VECTOR) |=> program_counter == `PCS_VECTOR)
        else $error("vector address wrong");

    a_step_inc: assert property (@(posedge mclk) disable iff (!rstn)
        (op_valid && op_code == PCS_OP_STEP) |=>
        program_counter == $past(program_counter) + 13'h0001)
        else $error("step did not advance counter");

    a_ready_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        pready |=> !pready)
        else $error("pready held past one cycle");

endmodule

`default_nettype wire

/* File: verification/program_counter_stack_indirect_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"

module program_counter_stack_indirect_test
    import pcs_pkg::*;
    ;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic op_valid = 1'b0;
    pcs_op_t op_code = PCS_OP_STEP;
    logic op_add = 1'b0;
    logic [10:0] op_target = 11'h000;
    logic [7:0] op_data = 8'h00;
    logic [12:0] program_counter;
    logic win_req = 1'b0;
    logic win_we = 1'b0;
    logic [7:0] win_wdata = 8'h00;
    logic win_rvalid;
    logic [7:0] win_rdata;
    logic mem_req;
    logic mem_we;
    logic [8:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata = 8'h00;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [33:0] apb_q[$];
    logic [7:0] win_q[$];
    logic [17:0] mem_q[$];
    logic [33:0] ea;
    logic [17:0] em;
    logic [7:0] mem_m [512];
    logic [7:0] ref_m [512];
    logic [12:0] stk [8];
    logic [12:0] pc_m = 13'h0000;
    logic [2:0] sp = 3'h0;
    logic [4:0] latch_m = 5'h00;
    logic [7:0] ptr_m = 8'h00;
    logic bank_m = 1'b0;
    logic [7:0] d8;
    pcs_op_t pops [3] = '{PCS_OP_RETURN, PCS_OP_RET_LIT, PCS_OP_INT_EXIT};

    always #2.5 mclk = ~mclk;

    pcs_core #(.DEPTH(8)) u_dut (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_add(op_add),
        .op_target(op_target), .op_data(op_data), .program_counter(program_counter),
        .win_req(win_req), .win_we(win_we), .win_wdata(win_wdata),
        .win_rvalid(win_rvalid), .win_rdata(win_rdata), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read data is only judged on reads; write data phase is unspecified
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        apb_q.push_back({~w, err, exp});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    // Ops are left asserted so back-to-back ops never toggle op_valid in one step
    task automatic op(input pcs_op_t c, input logic [10:0] t, input logic [7:0] d,
                      input logic a);
        case (c)
            PCS_OP_STEP: pc_m = pc_m + 13'h0001;
            PCS_OP_JUMP: pc_m = {latch_m[4:3], t};
            PCS_OP_CALL: begin
                stk[sp] = pc_m + 13'h0001;
                sp++;
                pc_m = {latch_m[4:3], t};
            end
            PCS_OP_VECTOR: begin
                stk[sp] = pc_m;
                sp++;
                pc_m = `PCS_VECTOR;
            end
            PCS_OP_LOW_WRITE: pc_m = {latch_m, a ? pc_m[7:0] + d : d};
            default: begin
                sp--;
                pc_m = stk[sp];
            end
        endcase
        op_valid <= 1'b1;
        op_code <= c;
        op_target <= t;
        op_data <= d;
        op_add <= a;
        @(posedge mclk);
    endtask

    task automatic pc_chk();
        op_valid <= 1'b0;
        rd(`PCS_OFF_COUNTER, {19'h0, pc_m});
    endtask

    task automatic win(input logic via_apb, input logic we, input logic [7:0] d);
        logic [8:0] a;
        logic [7:0] e;
        a = {bank_m, ptr_m};
        e = (ptr_m[6:0] == 7'h00) ? 8'h00 : ref_m[a];
        if (ptr_m[6:0] != 7'h00) begin
            mem_q.push_back({we, a, d});
            if (we) ref_m[a] = d;
        end
        if (via_apb) begin
            apb(we, `PCS_OFF_WINDOW, {24'h0, d}, {24'h0, e}, 1'b0);
        end else begin
            if (!we) win_q.push_back(e);
            win_req <= 1'b1;
            win_we <= we;
            win_wdata <= d;
            @(posedge mclk);
            win_req <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask

    always @(posedge mclk) begin
        if (pready === 1'b1) begin
            ea = (apb_q.size() != 0) ? apb_q.pop_front() : 34'h1_FFFF_FFFF;
            chk("pslverr", {31'h0, ea[32]}, {31'h0, pslverr});
            if (ea[33]) chk("prdata", ea[31:0], prdata);
        end
        if (win_rvalid === 1'b1) begin
            chk("win_rdata", {24'h0, win_q.pop_front()}, {24'h0, win_rdata});
        end
        if (mem_req === 1'b1) begin
            chk("mem_req", {31'h0, mem_q.size() != 0}, 32'h1);
            em = mem_q.pop_front();
            chk("mem_addr", {23'h0, em[16:8]}, {23'h0, mem_addr});
            chk("mem_we", {31'h0, em[17]}, {31'h0, mem_we});
            if (em[17]) chk("mem_wdata", {24'h0, em[7:0]}, {24'h0, mem_wdata});
            if (mem_we === 1'b1) mem_m[mem_addr] <= mem_wdata;
        end
        // An unread data line never holds still, so stale data cannot pass
        mem_rdata <= (mem_req === 1'b1) ? mem_m[mem_addr] : ~mem_rdata;
        // Last in the process so nothing runs after the verdict
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        void'($urandom(97));
        for (int i = 0; i < 512; i++) begin
            mem_m[i] = i[7:0] ^ 8'hA5;
            ref_m[i] = i[7:0] ^ 8'hA5;
        end
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(`PCS_OFF_LOW, 32'h0);
        rd(`PCS_OFF_LATCH, 32'h0);
        rd(`PCS_OFF_POINTER, 32'h0);
        rd(`PCS_OFF_STATUS, 32'h0);
        pc_chk();
        apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h018, 32'h1F, 32'h0, 1'b1);
        wr(`PCS_OFF_COUNTER, 32'h1FFF);
        pc_chk();
        latch_m = 5'($urandom());
        wr(`PCS_OFF_LATCH, {27'h0, latch_m});
        rd(`PCS_OFF_LATCH, {27'h0, latch_m});
        d8 = 8'($urandom());
        wr(`PCS_OFF_LOW, {24'h0, d8});
        pc_m = {latch_m, d8};
        pc_chk();
        rd(`PCS_OFF_LOW, {24'h0, d8});
        op(PCS_OP_JUMP, 11'($urandom()), 8'h00, 1'b0);
        pc_chk();
        op(PCS_OP_STEP, 11'h000, 8'h00, 1'b0);
        pc_chk();
        repeat (10) op(PCS_OP_CALL, 11'($urandom()), 8'h00, 1'b0);
        op(PCS_OP_VECTOR, 11'h000, 8'h00, 1'b0);
        pc_chk();
        for (int i = 0; i < 9; i++) begin
            op(pops[i % 3], 11'h000, 8'h00, 1'b0);
            pc_chk();
        end
        rd(`PCS_OFF_LATCH, {27'h0, latch_m});
        // Software low-byte write has to wait out three decoder ops
        d8 = 8'($urandom());
        fork
            begin
                repeat (3) op(PCS_OP_STEP, 11'h000, 8'h00, 1'b0);
                op_valid <= 1'b0;
            end
            wr(`PCS_OFF_LOW, {24'h0, d8});
        join
        pc_m = {latch_m, d8};
        pc_chk();
        op(PCS_OP_CALL, 11'($urandom()), 8'h00, 1'b0);
        op(PCS_OP_RETURN, 11'h000, 8'h00, 1'b0);
        pc_chk();
        op(PCS_OP_LOW_WRITE, 11'h000, 8'hF0, 1'b0);
        op(PCS_OP_LOW_WRITE, 11'h000, 8'h20, 1'b1);
        pc_chk();
        // Reset in mid-run, with the counter away from zero
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        pc_m = `PCS_RST_PC;
        sp = 3'h0;
        latch_m = `PCS_RST_LATCH;
        pc_chk();
        rd(`PCS_OFF_LATCH, {27'h0, latch_m});
        for (int j = 0; j < 2; j++) begin
            bank_m = j[0];
            wr(`PCS_OFF_STATUS, {24'h0, bank_m, 7'h00});
            rd(`PCS_OFF_STATUS, {24'h0, bank_m, 7'h00});
            ptr_m = 8'($urandom()) | 8'h01;
            wr(`PCS_OFF_POINTER, {24'h0, ptr_m});
            rd(`PCS_OFF_POINTER, {24'h0, ptr_m});
            d8 = 8'($urandom());
            win(1'b0, 1'b1, d8);
            win(1'b0, 1'b0, 8'h00);
            win(1'b1, 1'b1, ~d8);
            win(1'b1, 1'b0, 8'h00);
            ptr_m = {j[0], 7'h00};
            wr(`PCS_OFF_POINTER, {24'h0, ptr_m});
            win(1'b0, 1'b0, 8'h00);
            win(1'b0, 1'b1, 8'hFF);
            win(1'b1, 1'b0, 8'h00);
            win(1'b1, 1'b1, 8'h3C);
        end
        results();
    end
endmodule

`default_nettype wire
